// ===== common/tlsq_pkg.sv
// shared constants and types of the lock-status query handler
`default_nettype none
package tlsq_pkg;
   localparam int           UID_W        = 40;
   localparam int           LBN_W        = 3;
   localparam int           LOCK_W       = 32;
   localparam int           MAKER_W      = 8;
   localparam int           SIG_W        = 4;
   localparam int           CODE_W       = 6;
   localparam int           SHIFT_W      = 128;
   localparam int           LEN_W        = 8;
   localparam int           CRC_W        = 16;
   localparam int           GROUPS       = 8;
   localparam int           CUST_W       = 32;
   localparam int           CUST_LEN_W   = 6;
   localparam int           BLKCNT_W     = 9;

   localparam logic [5:0]   CMD_LOCK_QUERY    = 6'h11;
   // custom command code slot, plain default
   localparam logic [5:0]   CMD_CUSTOM        = 6'h20;
   localparam logic [7:0]   ERR_NOT_SUPPORTED = 8'h01;
   localparam logic [1:0]   FLAGS_OK          = 2'h0;
   localparam logic [1:0]   FLAGS_ERR         = 2'h1;
   // 2+1+1+4+40+32+32 payload bits ahead of the crc
   localparam logic [7:0]   LEN_QUERY         = 8'h70;
   // flags and one error code byte
   localparam logic [7:0]   LEN_ERROR         = 8'h0A;
   localparam logic [7:0]   LEN_FLAGS         = 8'h02;
   localparam logic [4:0]   CRC_BITS          = 5'h10;
   localparam logic [15:0]  CRC_PRESET        = 16'hFFFF;
   localparam logic [15:0]  CRC_POLY          = 16'h1021;
   localparam logic [63:0]  MEM_RESET         = 64'h0;

   typedef enum logic [2:0] {
      TLSQ_READY         = 3'h0,
      TLSQ_QUIET         = 3'h1,
      TLSQ_SELECTED      = 3'h2,
      TLSQ_ROUND_ACTIVE  = 3'h3,
      TLSQ_ROUND_STANDBY = 3'h4
   } tlsq_tag_state_t;

   typedef enum logic [2:0] {
      TLSQ_IDLE = 3'b001,
      TLSQ_LOAD = 3'b010,
      TLSQ_SEND = 3'b100
   } tlsq_fsm_t;

   typedef enum logic [1:0] {
      TLSQ_KIND_QUERY  = 2'h0,
      TLSQ_KIND_ERR    = 2'h1,
      TLSQ_KIND_CUSTOM = 2'h2
   } tlsq_kind_t;
endpackage
`default_nettype wire

// ===== common/tlsq_tx_if.sv
// handoff of a built response to the serializer
`default_nettype none
interface tlsq_tx_if;
   logic                   start;
   logic [127:0]           data;
   logic [7:0]             len;
   logic                   crc_en;
   logic                   busy;
   modport ctrl (output start, output data, output len, output crc_en, input busy);
   modport ser  (input start, input data, input len, input crc_en, output busy);
endinterface
`default_nettype wire

// ===== logic/tlsq_handler.sv
// lock-status query and custom command handler, tag side
//
// Operation
// [RULE1] code 17 query returns lock state of the requested block range
// [RULE2] lock block number is a 3-bit value, zero through seven
// [RULE3] addressed query: ext, code, flag 1, block, crc-5, 40-bit id, crc-16
// [RULE4] unaddressed query: flag 0, ends at crc-5, selected tag only
// [RULE5] query unsupported by selected or matching tag answers error code 1
// [RULE6] detected error condition sends error response instead of lock data
// [RULE7] success: flags, type, battery, signature, id, user, factory, crc-16
// [RULE8] each lock field covers 32 consecutive blocks from the first block
// [RULE9] blocks absent from memory read as zero
// [RULE10] first block at least significant bit, 32nd at most significant bit
// [RULE11] unselected or non-matching tag stays silent
// [RULE12] ready, quiet, round states answer only on identifier match
// [RULE13] selected answers flag 0 or matching id, ignores mismatch
// [RULE14] custom command: ext, 6-bit code, 4 flags, maker code, parameters
// [RULE15] custom command is ours only when the maker code matches
// [RULE16] custom success response starts with 2 flag bits then parameters
// [RULE17] unimplemented custom command at addressed tag answers error code 1
// [RULE18] commands failing crc-5 or crc-16 are dropped without effect
`default_nettype none
module tlsq_handler (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         cmd_valid_i,
   input  wire logic         cmd_proto_ext_i,
   input  wire logic [5:0]   cmd_code_i,
   input  wire logic         cmd_id_flag_i,
   input  wire logic [2:0]   cmd_lock_blk_i,
   input  wire logic         cmd_crc5_ok_i,
   input  wire logic         cmd_crc16_ok_i,
   input  wire logic [39:0]  cmd_uid_i,
   input  wire logic [7:0]   cmd_maker_i,
   input  wire logic [2:0]   tag_state_i,
   input  wire logic [39:0]  tag_unique_identifier_i,
   input  wire logic [7:0]   chip_maker_code_i,
   input  wire logic         tag_type_i,
   input  wire logic         battery_i,
   input  wire logic [3:0]   signature_i,
   input  wire logic         query_supported_i,
   input  wire logic         custom_supported_i,
   input  wire logic         query_err_i,
   input  wire logic [7:0]   query_err_code_i,
   input  wire logic [8:0]   mem_blocks_i,
   input  wire logic [31:0]  custom_rsp_i,
   input  wire logic [5:0]   custom_rsp_len_i,
   input  wire logic         lock_wr_i,
   input  wire logic [7:0]   lock_wr_blk_i,
   input  wire logic [1:0]   lock_wr_bits_i,
   input  wire logic         resp_ready_i,
   output logic              resp_bit_o,
   output logic              resp_valid_o,
   output logic              resp_last_o,
   output logic              busy_o,
   output logic              discard_o,
   output logic              custom_hit_o
);
   tlsq_tx_if tx ();

   tlsq_pkg::tlsq_fsm_t  fsm_r;
   tlsq_pkg::tlsq_kind_t kind_r;
   tlsq_pkg::tlsq_kind_t kind_nxt;
   logic [7:0]           err_code_r;
   logic [7:0]           err_code_nxt;
   logic [31:0]          mask_r;
   logic [31:0]          mask_nxt;
   logic [31:0]          cust_r;
   logic [5:0]           cust_len_r;
   logic [63:0]          lock_rd;
   logic                 start_r;
   logic [127:0]         data_r;
   logic [7:0]           len_r;
   logic                 crc_en_r;
   logic                 crc_ok;
   logic                 addr_ok;
   logic                 is_query;
   logic                 is_custom;
   logic                 maker_ok;
   logic                 take;
   logic                 idle;

   // answer only when selected without id, or the id matches
   function automatic logic addressed(input logic [2:0] st, input logic idf, input logic hit);
      return idf ? hit : (st == tlsq_pkg::TLSQ_SELECTED);
   endfunction

   assign idle      = (fsm_r == tlsq_pkg::TLSQ_IDLE);
   assign tx.start  = start_r;
   assign tx.data   = data_r;
   assign tx.len    = len_r;
   assign tx.crc_en = crc_en_r;

   always_comb begin
      // id form carries crc-16 as well
      crc_ok = cmd_crc5_ok_i && (!cmd_id_flag_i || cmd_crc16_ok_i); // [RULE3] [RULE4] [RULE18]
      // state held outside; only the answer depends on it
      addr_ok = addressed(tag_state_i, cmd_id_flag_i,
                          cmd_uid_i == tag_unique_identifier_i); // [RULE12] [RULE13]
      is_query  = !cmd_proto_ext_i && (cmd_code_i == tlsq_pkg::CMD_LOCK_QUERY); // [RULE1]
      is_custom = !cmd_proto_ext_i && (cmd_code_i == tlsq_pkg::CMD_CUSTOM); // [RULE14]
      maker_ok  = (cmd_maker_i == chip_maker_code_i); // [RULE15]
      take = cmd_valid_i && idle && crc_ok && addr_ok
             && (is_query || (is_custom && maker_ok)); // [RULE11]
   end

   always_comb begin
      kind_nxt = tlsq_pkg::TLSQ_KIND_ERR;
      err_code_nxt = tlsq_pkg::ERR_NOT_SUPPORTED; // [RULE5] [RULE17]
      if (is_query) begin
         if (query_supported_i && query_err_i) begin
            err_code_nxt = query_err_code_i; // [RULE6]
         end else if (query_supported_i) begin
            kind_nxt = tlsq_pkg::TLSQ_KIND_QUERY;
         end
      end else if (custom_supported_i) begin
         kind_nxt = tlsq_pkg::TLSQ_KIND_CUSTOM;
      end
   end

   // block index = group*32 + k, kept only below the memory size
   for (genvar k = 0; k < tlsq_pkg::LOCK_W; k++) begin : g_mask
      assign mask_nxt[k] = {1'b0, cmd_lock_blk_i, 5'(k)} < mem_blocks_i; // [RULE2] [RULE8] [RULE9]
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fsm_r <= tlsq_pkg::TLSQ_IDLE;
      end else begin
         case (fsm_r)
            tlsq_pkg::TLSQ_IDLE: begin
               if (take) begin
                  fsm_r <= tlsq_pkg::TLSQ_LOAD;
               end
            end
            tlsq_pkg::TLSQ_LOAD: begin
               fsm_r <= tlsq_pkg::TLSQ_SEND;
            end
            tlsq_pkg::TLSQ_SEND: begin
               // start_r still high in the first send cycle, before valid rises
               if (!tx.busy && !start_r) begin
                  fsm_r <= tlsq_pkg::TLSQ_IDLE;
               end
            end
            default: begin
               fsm_r <= tlsq_pkg::TLSQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         kind_r <= tlsq_pkg::TLSQ_KIND_ERR;
         err_code_r <= 8'h00;
         mask_r <= 32'h0;
         cust_r <= 32'h0;
         cust_len_r <= 6'h00;
      end else if (take) begin
         kind_r <= kind_nxt;
         err_code_r <= err_code_nxt;
         mask_r <= mask_nxt;
         cust_r <= custom_rsp_i;
         cust_len_r <= custom_rsp_len_i;
      end
   end

   // response build, one cycle after the lock word is read
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_r <= 1'b0;
         data_r <= 128'h0;
         len_r <= 8'h00;
         crc_en_r <= 1'b0;
      end else if (fsm_r == tlsq_pkg::TLSQ_LOAD) begin
         start_r <= 1'b1;
         crc_en_r <= 1'b1;
         case (kind_r)
            tlsq_pkg::TLSQ_KIND_QUERY: begin
               // lock fields sent msb first: 32nd block leads, first block trails
               data_r <= {tlsq_pkg::FLAGS_OK, tag_type_i, battery_i, signature_i,
                          tag_unique_identifier_i, lock_rd[31:0] & mask_r,
                          lock_rd[63:32] & mask_r, 16'h0000}; // [RULE7] [RULE8] [RULE9] [RULE10]
               len_r <= tlsq_pkg::LEN_QUERY;
            end
            tlsq_pkg::TLSQ_KIND_CUSTOM: begin
               data_r <= {tlsq_pkg::FLAGS_OK, cust_r, 94'h0}; // [RULE16]
               len_r <= tlsq_pkg::LEN_FLAGS + {2'b00, cust_len_r};
            end
            default: begin
               data_r <= {tlsq_pkg::FLAGS_ERR, err_code_r, 118'h0}; // [RULE5] [RULE6] [RULE17]
               len_r <= tlsq_pkg::LEN_ERROR;
            end
         endcase
      end else begin
         start_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         discard_o <= 1'b0;
         custom_hit_o <= 1'b0;
      end else begin
         busy_o <= take || (!idle && !(fsm_r == tlsq_pkg::TLSQ_SEND && !tx.busy && !start_r));
         discard_o <= cmd_valid_i && idle && !crc_ok; // [RULE18]
         custom_hit_o <= take && is_custom && custom_supported_i;
      end
   end

   tlsq_lock_mem u_mem (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .wr_en_i   (lock_wr_i),
      .wr_blk_i  (lock_wr_blk_i),
      .wr_bits_i (lock_wr_bits_i),
      .rd_en_i   (take),
      .rd_grp_i  (cmd_lock_blk_i),
      .rd_data_o (lock_rd)
   );

   tlsq_resp_ser u_ser (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .tx           (tx),
      .resp_ready_i (resp_ready_i),
      .resp_bit_o   (resp_bit_o),
      .resp_valid_o (resp_valid_o),
      .resp_last_o  (resp_last_o)
   );

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   logic good_query;
   logic deaf_query;
   assign good_query = cmd_valid_i && idle && crc_ok && addr_ok && is_query;
   assign deaf_query = cmd_valid_i && idle && crc_ok && is_query;

   property p_query_answer;
      good_query && query_supported_i && !query_err_i
      |-> ##2 start_r && len_r == tlsq_pkg::LEN_QUERY && data_r[127:126] == 2'h0;
   endproperty
   a_query_answer: assert property (p_query_answer) else $error("query not answered"); // [RULE1]

   property p_query_layout;
      start_r && len_r == tlsq_pkg::LEN_QUERY
      |-> data_r[119:80] == tag_unique_identifier_i && data_r[15:0] == 16'h0000;
   endproperty
   a_query_layout: assert property (p_query_layout) else $error("bad query layout"); // [RULE7]

   property p_zero_fill;
      start_r && len_r == tlsq_pkg::LEN_QUERY
      |-> (data_r[79:48] & ~mask_r) == 32'h0 && (data_r[47:16] & ~mask_r) == 32'h0;
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("absent block not zero"); // [RULE9]

   property p_not_supported;
      good_query && !query_supported_i
      |-> ##2 start_r && data_r[127:118] == {tlsq_pkg::FLAGS_ERR, tlsq_pkg::ERR_NOT_SUPPORTED};
   endproperty
   a_not_supported: assert property (p_not_supported) else $error("missing error 1"); // [RULE5]

   property p_err_cond;
      good_query && query_supported_i && query_err_i
      |-> ##2 start_r && len_r == tlsq_pkg::LEN_ERROR && data_r[127:126] == tlsq_pkg::FLAGS_ERR;
   endproperty
   a_err_cond: assert property (p_err_cond) else $error("error response missing"); // [RULE6]

   property p_silent;
      deaf_query && !addr_ok |=> fsm_r == tlsq_pkg::TLSQ_IDLE ##1 !start_r;
   endproperty
   a_silent: assert property (p_silent) else $error("unaddressed tag answered"); // [RULE11]

   property p_selected_no_id;
      deaf_query && tag_state_i == tlsq_pkg::TLSQ_SELECTED && !cmd_id_flag_i
      |=> fsm_r == tlsq_pkg::TLSQ_LOAD;
   endproperty
   a_selected_no_id: assert property (p_selected_no_id) else $error("selected tag ignored"); // [RULE13]

   property p_other_state_no_id;
      deaf_query && tag_state_i != tlsq_pkg::TLSQ_SELECTED && !cmd_id_flag_i
      |=> fsm_r == tlsq_pkg::TLSQ_IDLE;
   endproperty
   a_other_state_no_id: assert property (p_other_state_no_id) else $error("answered unselected"); // [RULE12]

   property p_crc_drop;
      cmd_valid_i && idle && !crc_ok |=> discard_o && fsm_r == tlsq_pkg::TLSQ_IDLE;
   endproperty
   a_crc_drop: assert property (p_crc_drop) else $error("bad crc not dropped"); // [RULE18]

   property p_maker_mismatch;
      cmd_valid_i && idle && is_custom && !maker_ok |=> fsm_r == tlsq_pkg::TLSQ_IDLE;
   endproperty
   a_maker_mismatch: assert property (p_maker_mismatch) else $error("foreign custom taken"); // [RULE15]

   property p_custom_ok;
      take && is_custom && custom_supported_i
      |-> ##2 start_r && data_r[127:126] == tlsq_pkg::FLAGS_OK
          && len_r == tlsq_pkg::LEN_FLAGS + {2'b00, $past(custom_rsp_len_i, 2)};
   endproperty
   a_custom_ok: assert property (p_custom_ok) else $error("custom response wrong"); // [RULE16]

   property p_custom_unsup;
      take && is_custom && !custom_supported_i
      |-> ##2 start_r && data_r[127:118] == {tlsq_pkg::FLAGS_ERR, tlsq_pkg::ERR_NOT_SUPPORTED};
   endproperty
   a_custom_unsup: assert property (p_custom_unsup) else $error("custom error 1 missing"); // [RULE17]

   property p_busy_while_sending;
      resp_valid_o |-> busy_o && !idle;
   endproperty
   a_busy_while_sending: assert property (p_busy_while_sending) else $error("idle while sending"); // [RULE1]

   c_query_sent:  cover property (start_r && len_r == tlsq_pkg::LEN_QUERY);
   c_error_sent:  cover property (start_r && len_r == tlsq_pkg::LEN_ERROR);
   c_custom_sent: cover property (start_r && kind_r == tlsq_pkg::TLSQ_KIND_CUSTOM);
   c_resp_done:   cover property (resp_valid_o && resp_ready_i && resp_last_o);
endmodule
`default_nettype wire

// ===== logic/tlsq_lock_mem.sv
// lock bits of 256 blocks, eight groups of 32, registered read
`default_nettype none
module tlsq_lock_mem (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        wr_en_i,
   input  wire logic [7:0]  wr_blk_i,
   input  wire logic [1:0]  wr_bits_i,
   input  wire logic        rd_en_i,
   input  wire logic [2:0]  rd_grp_i,
   output logic      [63:0] rd_data_o
);
   logic [63:0] mem_r [tlsq_pkg::GROUPS];

   // user bit at [blk], factory bit at [32+blk]
   for (genvar g = 0; g < tlsq_pkg::GROUPS; g++) begin : g_word
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            mem_r[g] <= tlsq_pkg::MEM_RESET;
         end else if (wr_en_i && wr_blk_i[7:5] == 3'(g)) begin
            mem_r[g][{1'b0, wr_blk_i[4:0]}] <= wr_bits_i[0];
            mem_r[g][{1'b1, wr_blk_i[4:0]}] <= wr_bits_i[1];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= tlsq_pkg::MEM_RESET;
      end else if (rd_en_i) begin
         rd_data_o <= mem_r[rd_grp_i];
      end
   end
endmodule
`default_nettype wire

// ===== logic/tlsq_resp_ser.sv
// msb-first response serializer with trailing crc-16
`default_nettype none
module tlsq_resp_ser (
   input  wire logic  clk_i,
   input  wire logic  rst_n_i,
   tlsq_tx_if.ser     tx,
   input  wire logic  resp_ready_i,
   output logic       resp_bit_o,
   output logic       resp_valid_o,
   output logic       resp_last_o
);
   logic [127:0] sh_r;
   logic [7:0]   cnt_r;
   logic [4:0]   ccnt_r;
   logic [15:0]  crc_r;
   logic [15:0]  crc_nxt;
   logic         crc_en_r;
   logic         in_crc_r;
   logic         fire;

   assign tx.busy = resp_valid_o;
   assign fire    = resp_valid_o && resp_ready_i;

   always_comb begin
      crc_nxt = {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ resp_bit_o) ? tlsq_pkg::CRC_POLY : 16'h0000);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_r <= 128'h0;
         cnt_r <= 8'h00;
         ccnt_r <= 5'h00;
         crc_r <= tlsq_pkg::CRC_PRESET;
         crc_en_r <= 1'b0;
         in_crc_r <= 1'b0;
         resp_bit_o <= 1'b0;
         resp_valid_o <= 1'b0;
         resp_last_o <= 1'b0;
      end else if (tx.start && !resp_valid_o) begin
         resp_bit_o <= tx.data[127];
         sh_r <= {tx.data[126:0], 1'b0};
         cnt_r <= tx.len;
         crc_en_r <= tx.crc_en;
         crc_r <= tlsq_pkg::CRC_PRESET;
         in_crc_r <= 1'b0;
         resp_valid_o <= 1'b1;
         resp_last_o <= (tx.len == 8'h01) && !tx.crc_en;
      end else if (fire && !in_crc_r) begin
         if (cnt_r != 8'h01) begin
            resp_bit_o <= sh_r[127];
            sh_r <= {sh_r[126:0], 1'b0};
            cnt_r <= cnt_r - 8'h01;
            crc_r <= crc_nxt;
            resp_last_o <= (cnt_r == 8'h02) && !crc_en_r;
         end else if (crc_en_r) begin
            // crc goes out inverted, msb first
            in_crc_r <= 1'b1;
            ccnt_r <= tlsq_pkg::CRC_BITS;
            resp_bit_o <= ~crc_nxt[15];
            crc_r <= {crc_nxt[14:0], 1'b0};
            resp_last_o <= 1'b0;
         end else begin
            resp_valid_o <= 1'b0;
            resp_last_o <= 1'b0;
         end
      end else if (fire) begin
         if (ccnt_r != 5'h01) begin
            resp_bit_o <= ~crc_r[15];
            crc_r <= {crc_r[14:0], 1'b0};
            ccnt_r <= ccnt_r - 5'h01;
            resp_last_o <= (ccnt_r == 5'h02);
         end else begin
            resp_valid_o <= 1'b0;
            resp_last_o <= 1'b0;
            in_crc_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/tlsq_handler_tb.sv
// self-checking bench of the lock-status query handler
`default_nettype none
module tlsq_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk_i, rst_n_i, cmd_valid_i, cmd_proto_ext_i, cmd_id_flag_i;
   logic         cmd_crc5_ok_i, cmd_crc16_ok_i, tag_type_i, battery_i, lock_wr_i;
   logic         query_supported_i, custom_supported_i, query_err_i, resp_ready_i;
   logic         resp_bit_o, resp_valid_o, resp_last_o, busy_o, discard_o, custom_hit_o;
   logic         clr, slow, done, disc_seen, hit_seen;
   logic [5:0]   cmd_code_i, custom_rsp_len_i;
   logic [2:0]   cmd_lock_blk_i, tag_state_i;
   logic [39:0]  cmd_uid_i, tag_unique_identifier_i;
   logic [7:0]   cmd_maker_i, chip_maker_code_i, query_err_code_i, lock_wr_blk_i, cnt;
   logic [3:0]   signature_i;
   logic [8:0]   mem_blocks_i;
   logic [31:0]  custom_rsp_i;
   logic [1:0]   lock_wr_bits_i;
   logic [159:0] rx, exp;
   logic [127:0] pay;
   logic         usr [256];
   logic         fac [256];
   logic [2:0]   st [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
   int           error_cnt, tests_run;

   tlsq_handler uut (.clk_i, .rst_n_i, .cmd_valid_i, .cmd_proto_ext_i, .cmd_code_i,
      .cmd_id_flag_i, .cmd_lock_blk_i, .cmd_crc5_ok_i, .cmd_crc16_ok_i, .cmd_uid_i,
      .cmd_maker_i, .tag_state_i, .tag_unique_identifier_i, .chip_maker_code_i,
      .tag_type_i, .battery_i, .signature_i, .query_supported_i, .custom_supported_i,
      .query_err_i, .query_err_code_i, .mem_blocks_i, .custom_rsp_i, .custom_rsp_len_i,
      .lock_wr_i, .lock_wr_blk_i, .lock_wr_bits_i, .resp_ready_i, .resp_bit_o,
      .resp_valid_o, .resp_last_o, .busy_o, .discard_o, .custom_hit_o);
   tlsq_link_model link (.clk_i, .rst_n_i, .clr_i(clr), .slow_i(slow), .resp_bit_i(resp_bit_o),
      .resp_valid_i(resp_valid_o), .resp_last_i(resp_last_o), .resp_ready_o(resp_ready_i),
      .rx_o(rx), .cnt_o(cnt), .done_o(done));

   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (discard_o === 1'b1) disc_seen <= 1'b1;
      if (custom_hit_o === 1'b1) hit_seen <= 1'b1;
   end

   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic print_verdict;
      $display("TB: %0d errors in %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input int b, input logic [1:0] bits);
      @(posedge clk_i); #1;
      lock_wr_i = 1'b1; lock_wr_blk_i = 8'(b); lock_wr_bits_i = bits;
      usr[b] = bits[0]; fac[b] = bits[1];
      @(posedge clk_i); #1;
      lock_wr_i = 1'b0;
   endtask
   // one-cycle command pulse; the model clears at the taking edge
   task automatic cmd(input logic [5:0] c, input logic f, input logic [39:0] u);
      @(posedge clk_i); #1;
      clr = 1'b1; disc_seen = 1'b0; hit_seen = 1'b0;
      cmd_code_i = c; cmd_id_flag_i = f; cmd_uid_i = u; cmd_valid_i = 1'b1;
      @(posedge clk_i); #1;
      clr = 1'b0; cmd_valid_i = 1'b0;
   endtask
   task automatic frame(input int len, input string msg);
      logic [15:0] c;
      logic        fb;
      int          i;
      c = 16'hFFFF;
      for (i = len - 1; i >= 0; i--) begin
         fb = c[15] ^ pay[i];
         c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
      exp = ({32'h0, pay} << 16) | {144'h0, ~c};
      i = 0;
      while ((done !== 1'b1 || busy_o !== 1'b0) && i < 700) begin
         @(posedge clk_i); #1;
         i++;
      end
      check(done === 1'b1 && cnt === 8'(len + 16) && rx === exp, msg);
   endtask
   task automatic quiet(input string msg);
      repeat (10) @(posedge clk_i);
      #1;
      check(cnt === 8'h00 && busy_o === 1'b0, msg);
   endtask
   function automatic logic [31:0] field(input logic f, input logic [2:0] g);
      logic [31:0] v;
      int          b;
      for (int k = 0; k < 32; k++) begin
         b = g * 32 + k;
         v[k] = (b < mem_blocks_i) ? (f ? fac[b] : usr[b]) : 1'b0;
      end
      return v;
   endfunction
   task automatic query(input logic [2:0] g, input logic f, input logic [39:0] u, string m);
      cmd_lock_blk_i = g;
      cmd(tlsq_pkg::CMD_LOCK_QUERY, f, u);
      pay = {16'h0, tlsq_pkg::FLAGS_OK, tag_type_i, battery_i, signature_i,
         tag_unique_identifier_i, field(1'b0, g), field(1'b1, g)};
      frame(112, m);
   endtask
   task automatic err(input logic [7:0] code, input string m);
      pay = {118'h0, tlsq_pkg::FLAGS_ERR, code};
      frame(10, m);
   endtask

   initial begin
      error_cnt = 0; tests_run = 0; rst_n_i = 1'b0; cmd_valid_i = 1'b0;
      cmd_proto_ext_i = 1'b0; cmd_id_flag_i = 1'b0; cmd_crc5_ok_i = 1'b1;
      cmd_crc16_ok_i = 1'b1; tag_type_i = 1'b1; battery_i = 1'b0; lock_wr_i = 1'b0;
      query_supported_i = 1'b1; custom_supported_i = 1'b1; query_err_i = 1'b0;
      clr = 1'b0; slow = 1'b0; cmd_code_i = 6'h00; custom_rsp_len_i = 6'h0C;
      cmd_lock_blk_i = 3'h0; tag_state_i = 3'h2; cmd_uid_i = 40'h0;
      tag_unique_identifier_i = 40'hC3_5A96_0F1E; cmd_maker_i = 8'h5A;
      chip_maker_code_i = 8'h5A; query_err_code_i = 8'h0F; lock_wr_blk_i = 8'h00;
      signature_i = 4'h9; mem_blocks_i = 9'h100; custom_rsp_i = 32'hA5C3_0F1E;
      lock_wr_bits_i = 2'h0; disc_seen = 1'b0; hit_seen = 1'b0;
      for (int b = 0; b < 256; b++) begin usr[b] = 1'b0; fac[b] = 1'b0; end
      repeat (4) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      quiet("reset leaves outputs low");
      wr(32, 2'b01); wr(63, 2'b10); wr(45, 2'b11); wr(224, 2'b10); wr(255, 2'b11);
      query(3'h1, 1'b0, 40'h0, "selected unaddressed query");
      slow = 1'b1;
      query(3'h7, 1'b0, 40'h0, "top group with stalls");
      slow = 1'b0;
      mem_blocks_i = 9'h028;
      query(3'h1, 1'b0, 40'h0, "absent blocks read zero");
      mem_blocks_i = 9'h100;
      foreach (st[i]) begin
         tag_state_i = st[i];
         query(3'h1, 1'b1, tag_unique_identifier_i, "addressed match answers");
         cmd(6'h11, 1'b0, 40'h0); quiet("unaddressed ignored");
         cmd(6'h11, 1'b1, 40'h1); quiet("addressed mismatch silent");
      end
      tag_state_i = 3'h2;
      cmd(6'h11, 1'b1, 40'h1); quiet("selected mismatch ignored");
      query(3'h0, 1'b1, tag_unique_identifier_i, "selected addressed match");
      cmd_crc16_ok_i = 1'b0;
      cmd(6'h11, 1'b1, tag_unique_identifier_i); quiet("crc16 fail silent");
      check(disc_seen === 1'b1, "crc16 fail discard pulse");
      cmd_crc16_ok_i = 1'b1; cmd_crc5_ok_i = 1'b0;
      cmd(6'h11, 1'b0, 40'h0); quiet("crc5 fail silent");
      check(disc_seen === 1'b1, "crc5 fail discard pulse");
      cmd_crc5_ok_i = 1'b1; query_supported_i = 1'b0;
      cmd(6'h11, 1'b0, 40'h0); err(8'h01, "unsupported query error");
      query_supported_i = 1'b1; query_err_i = 1'b1;
      cmd(6'h11, 1'b0, 40'h0); err(8'h0F, "query error response");
      query_err_i = 1'b0;
      cmd(tlsq_pkg::CMD_CUSTOM, 1'b0, 40'h0);
      pay = {114'h0, 2'b00, custom_rsp_i[31:20]};
      frame(14, "custom response");
      check(hit_seen === 1'b1, "custom hit pulse");
      cmd_maker_i = 8'hA5;
      cmd(tlsq_pkg::CMD_CUSTOM, 1'b0, 40'h0); quiet("foreign maker silent");
      cmd_maker_i = 8'h5A; custom_supported_i = 1'b0;
      cmd(tlsq_pkg::CMD_CUSTOM, 1'b0, 40'h0); err(8'h01, "unsupported custom");
      print_verdict();
   end
   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire

// ===== verification/tlsq_link_model.sv
// interrogator receiver model: collects response bits, can stall the link
`default_nettype none
module tlsq_link_model (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         clr_i,
   input  wire logic         slow_i,
   input  wire logic         resp_bit_i,
   input  wire logic         resp_valid_i,
   input  wire logic         resp_last_i,
   output logic              resp_ready_o,
   output logic      [159:0] rx_o,
   output logic      [7:0]   cnt_o,
   output logic              done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic phase_r;
   // slow mode accepts every other cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) phase_r <= 1'b0;
      else phase_r <= ~phase_r;
   end
   assign resp_ready_o = !slow_i || phase_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_o   <= '0;
         cnt_o  <= 8'h00;
         done_o <= 1'b0;
      end else if (clr_i) begin
         rx_o   <= '0;
         cnt_o  <= 8'h00;
         done_o <= 1'b0;
      end else if (resp_valid_i && resp_ready_o) begin
         rx_o   <= {rx_o[158:0], resp_bit_i};
         cnt_o  <= cnt_o + 8'h01;
         done_o <= done_o | resp_last_i;
      end
   end
endmodule
`default_nettype wire
